// >>> design/fifo_flag_core.sv
// Flag timing, mode straps and fall-through output stage of one FIFO bank
`timescale 1ns/10ps
`default_nettype none
module fifo_flag_core
	import fifo_cfg_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH,
	parameter int WIDTH = WORD_WIDTH
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic first_load_strap,
	input wire logic read_chain_in,
	input wire logic write_chain_in,
	input wire logic write_en_n,
	input wire logic [WIDTH-1:0] write_data,
	input wire logic read_en_n,
	input wire logic [$clog2(DEPTH+2)-1:0] empty_offset,
	input wire logic [$clog2(DEPTH+2)-1:0] full_offset,
	output logic [WIDTH-1:0] read_data,
	output logic empty_flag_n,
	output logic full_flag_n,
	output logic output_valid_n,
	output logic input_room_n,
	output logic almost_empty_n,
	output logic almost_full_n,
	output logic half_full_n,
	output logic read_chain_out,
	output logic fall_through_mode,
	output logic sync_partial,
	output logic stand_alone
);
	localparam int CW = $clog2(DEPTH + 1);
	localparam int OW = $clog2(DEPTH + 2);
	localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
	localparam logic [OW-1:0] STD_DEPTH = OW'(DEPTH);
	localparam logic [OW-1:0] FT_DEPTH = OW'(DEPTH + 1);

	// The lag chain needs a few words of store; a word of no bits means nothing
	if (DEPTH < MIN_DEPTH) begin : g_bad_depth
		$error("fifo_flag_core: DEPTH too small");
	end
	if (WIDTH < 1) begin : g_bad_width
		$error("fifo_flag_core: WIDTH must be at least one bit");
	end

	fifo_store_if #(.WIDTH(WIDTH), .CW(CW)) bus ();

	fifo_store #(.DEPTH(DEPTH), .WIDTH(WIDTH)) u_store (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.bus(bus)
	);

	// Strap synchronisers; no reset so they settle while reset is held
	// Straps must stay static: they are read once, at the first edge after release
	logic [2:0] strap_meta, strap_sync;
	always_ff @(posedge sys_clk) begin
		strap_meta <= {first_load_strap, read_chain_in, write_chain_in};
		strap_sync <= strap_meta;
	end

	logic cfg_done, next_cfg_done;
	logic dbl_buf, next_dbl_buf;
	logic next_ft, next_sync_partial, next_stand_alone;
	logic data_shown, next_data_shown, data_d1, next_data_d1;
	logic room_shown, next_room_shown, room_d1, next_room_d1;
	logic ft_valid, next_ft_valid;
	logic [WIDTH-1:0] out_word, next_out_word;
	logic next_ae_n, next_af_n, next_hf_n, next_chain_out;
	logic wr_ok, rd_ok, pop;
	logic [CW-1:0] next_count;
	logic [OW-1:0] occ, depth_now, ae_limit, af_limit;
	logic has_now, has_prev, room_now, room_prev;
	logic next_ef_n, next_ff_n, next_ov_n, next_ir_n;

	assign bus.wr = wr_ok;
	assign bus.wdata = write_data;
	assign bus.rd = pop;

	// Mode decode, taken once at the first edge after reset release
	always_comb begin
		next_cfg_done = 1'b1;
		next_ft = fall_through_mode;
		next_dbl_buf = dbl_buf;
		next_sync_partial = sync_partial;
		next_stand_alone = stand_alone;
		// Expansion codes 011 and 111 fall to standard single buffering
		if (!cfg_done) begin
			next_ft = (strap_sync == STRAP_001) || (strap_sync == STRAP_101);
			next_dbl_buf = (strap_sync == STRAP_010) || (strap_sync == STRAP_110);
			next_sync_partial = (strap_sync == STRAP_100) || (strap_sync == STRAP_101)
				|| (strap_sync == STRAP_110);
			next_stand_alone = (strap_sync == STRAP_000) || (strap_sync == STRAP_001)
				|| (strap_sync == STRAP_010) || (next_sync_partial);
		end
	end

	// Data movement: accepts, store pops and the output word
	// A refused write or read leaves every count and pointer untouched
	always_comb begin
		wr_ok = cfg_done && !write_en_n && room_shown;
		rd_ok = cfg_done && !read_en_n && data_shown;
		if (fall_through_mode) begin
			// Output register refills whenever it is empty or being read
			pop = (bus.count != '0) && (!ft_valid || rd_ok);
			next_ft_valid = pop || (ft_valid && !rd_ok);
		end else begin
			pop = rd_ok;
			next_ft_valid = 1'b0;
		end
		next_out_word = pop ? bus.rdata : out_word;
		next_count = bus.count + CW'(wr_ok) - CW'(pop);
		next_chain_out = bus.last_pop;
	end

	// Shown flags fall at once but rise with one or two edges of lag,
	// so a reader or writer never acts on a word or slot not yet there
	always_comb begin
		has_now = fall_through_mode ? next_ft_valid : (next_count != '0);
		has_prev = fall_through_mode ? ft_valid : (bus.count != '0);
		room_now = (next_count != FULL_COUNT);
		room_prev = (bus.count != FULL_COUNT);
		next_data_d1 = has_prev;
		next_room_d1 = room_prev;
		// Fall-through valid lands two edges after the write
		next_data_shown = has_now && has_prev && (!dbl_buf || data_d1);
		next_room_shown = room_now && room_prev && (!dbl_buf || room_d1);
	end

	// Partial and half flags from next occupancy; one clock serves both sides,
	// so each updates on the edge that moves the word
	always_comb begin
		occ = OW'(next_count) + OW'(next_ft_valid);
		depth_now = fall_through_mode ? FT_DEPTH : STD_DEPTH;
		ae_limit = fall_through_mode ? empty_offset + 1'b1 : empty_offset;
		af_limit = depth_now - full_offset;
		next_ae_n = !(occ <= ae_limit);
		next_af_n = !(occ >= af_limit);
		next_hf_n = !(occ > (depth_now >> 1));
	end

	// Flag pins: mode picks the standard or the fall-through pair,
	// and the pair not in use idles inactive high
	always_comb begin
		next_ef_n = next_ft ? FLAG_N_IDLE : next_data_shown;
		next_ff_n = next_ft ? FLAG_N_IDLE : next_room_shown;
		next_ov_n = next_ft ? !next_data_shown : FLAG_N_IDLE;
		next_ir_n = next_ft ? !next_room_shown : FLAG_N_IDLE;
	end

	// Control state; reset leaves the bank empty with room shown
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_done <= 1'b0;
			fall_through_mode <= 1'b0;
			dbl_buf <= 1'b0;
			sync_partial <= 1'b0;
			stand_alone <= 1'b0;
			data_shown <= DATA_SHOWN_RST;
			data_d1 <= DATA_SHOWN_RST;
			room_shown <= ROOM_SHOWN_RST;
			room_d1 <= ROOM_SHOWN_RST;
			ft_valid <= 1'b0;
			out_word <= '0;
			almost_empty_n <= 1'b0;
			almost_full_n <= FLAG_N_IDLE;
			half_full_n <= FLAG_N_IDLE;
			read_chain_out <= 1'b0;
		end else begin
			cfg_done <= next_cfg_done;
			fall_through_mode <= next_ft;
			dbl_buf <= next_dbl_buf;
			sync_partial <= next_sync_partial;
			stand_alone <= next_stand_alone;
			data_shown <= next_data_shown;
			data_d1 <= next_data_d1;
			room_shown <= next_room_shown;
			room_d1 <= next_room_d1;
			ft_valid <= next_ft_valid;
			out_word <= next_out_word;
			almost_empty_n <= next_ae_n;
			almost_full_n <= next_af_n;
			half_full_n <= next_hf_n;
			read_chain_out <= next_chain_out;
		end
	end

	// Output word and the four boundary flag pins, all registered
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			read_data <= '0;
			empty_flag_n <= 1'b0;
			full_flag_n <= FLAG_N_IDLE;
			output_valid_n <= FLAG_N_IDLE;
			input_room_n <= FLAG_N_IDLE;
		end else begin
			read_data <= next_out_word;
			empty_flag_n <= next_ef_n;
			full_flag_n <= next_ff_n;
			output_valid_n <= next_ov_n;
			input_room_n <= next_ir_n;
		end
	end
endmodule
`default_nettype wire

// >>> design/fifo_cfg_pkg.sv
// Shared constants for the flag timing and mode selection block
package fifo_cfg_pkg;
	localparam int WORD_WIDTH = 18;
	localparam int FIFO_DEPTH = 256;
	localparam int MIN_DEPTH = 4;
	// Strap codes, ordered first_load_strap, read_chain_in, write_chain_in
	localparam logic [2:0] STRAP_000 = 3'h0;
	localparam logic [2:0] STRAP_001 = 3'h1;
	localparam logic [2:0] STRAP_010 = 3'h2;
	localparam logic [2:0] STRAP_100 = 3'h4;
	localparam logic [2:0] STRAP_101 = 3'h5;
	localparam logic [2:0] STRAP_110 = 3'h6;
	// Reset values of the shown flags, and the inactive idle level of the flag pins
	localparam logic DATA_SHOWN_RST = 1'h0;
	localparam logic ROOM_SHOWN_RST = 1'h1;
	localparam logic FLAG_N_IDLE = 1'h1;
endpackage

// >>> design/fifo_store_if.sv
// Carrier between the flag core and the word store
`timescale 1ns/10ps
`default_nettype none
interface fifo_store_if #(parameter int WIDTH = 18, parameter int CW = 9);
	logic wr;
	logic [WIDTH-1:0] wdata;
	logic rd;
	logic [WIDTH-1:0] rdata;
	logic [CW-1:0] count;
	logic last_pop;
	modport core (output wr, output wdata, output rd, input rdata, input count, input last_pop);
	modport store (input wr, input wdata, input rd, output rdata, output count, output last_pop);
endinterface
`default_nettype wire

// >>> design/fifo_store.sv
// Word store with circular pointers and an occupancy count
`timescale 1ns/10ps
`default_nettype none
module fifo_store
	import fifo_cfg_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH,
	parameter int WIDTH = WORD_WIDTH
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	fifo_store_if.store bus
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [AW-1:0] LAST_ADDR = AW'(DEPTH - 1);

	if (DEPTH < MIN_DEPTH) begin : g_bad_depth
		$error("fifo_store: DEPTH too small");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [CW-1:0] count, next_count;

	// Read port is combinational so fall-through can load in one edge
	assign bus.rdata = mem[rd_ptr];
	assign bus.count = count;
	// Pop from the last physical location drives the chain pulse
	assign bus.last_pop = bus.rd && (rd_ptr == LAST_ADDR);

	// Pointer wrap and count arithmetic
	always_comb begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		if (bus.wr) begin
			next_wr_ptr = (wr_ptr == LAST_ADDR) ? '0 : wr_ptr + 1'b1;
		end
		if (bus.rd) begin
			next_rd_ptr = (rd_ptr == LAST_ADDR) ? '0 : rd_ptr + 1'b1;
		end
		next_count = count + CW'(bus.wr) - CW'(bus.rd);
	end

	// Array has no reset; only control state is cleared
	always_ff @(posedge sys_clk) begin
		if (bus.wr) begin
			mem[wr_ptr] <= bus.wdata;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
	end
endmodule
`default_nettype wire

// >>> testbench/fifo_peer_model.sv
// Writer and reader peer that drives the request side of one bank
`timescale 1ns/10ps
`default_nettype none
module fifo_peer_model (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [2:0] strap_sel,
	input wire logic wr_req,
	input wire logic rd_req,
	output logic first_load_strap,
	output logic read_chain_in,
	output logic write_chain_in,
	output logic write_en_n,
	output logic [17:0] write_data,
	output logic read_en_n
);
	logic [17:0] word_cnt = 18'h0;
	// Straps are static levels, changed by the bench only while reset holds
	assign {first_load_strap, read_chain_in, write_chain_in} = strap_sel;
	assign write_en_n = ~wr_req;
	assign read_en_n = ~rd_req;
	// Idle data is the inverse word, so a stale word never passes for a new one
	assign write_data = wr_req ? word_cnt : ~word_cnt;
	// A refused word is lost, as a real writer would lose it
	always @(negedge sys_clk or negedge rst_n) begin
		if (!rst_n) word_cnt <= 18'h0;
		else if (wr_req) word_cnt <= word_cnt + 18'h1;
	end
endmodule
`default_nettype wire

// >>> testbench/fifo_flag_core_monitor.sv
// Assertions on mode decode and flag latencies of one bank
`timescale 1ns/10ps
`default_nettype none
module fifo_flag_core_monitor (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic first_load_strap,
	input wire logic read_chain_in,
	input wire logic write_chain_in,
	input wire logic write_en_n,
	input wire logic read_en_n,
	input wire logic empty_flag_n,
	input wire logic full_flag_n,
	input wire logic output_valid_n,
	input wire logic input_room_n,
	input wire logic read_chain_out,
	input wire logic fall_through_mode,
	input wire logic sync_partial,
	input wire logic stand_alone
);
	logic [2:0] s;
	logic dbl;
	// Strap code and the double buffering it selects
	assign s = {first_load_strap, read_chain_in, write_chain_in};
	assign dbl = s == 3'h2 || s == 3'h6;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// One edge of lag, or two with double buffering
	sequence s_release(f);
		##1 !f ##1 (f ^ dbl) ##1 f;
	endsequence
	AST_FT_DECODE: assert property ($past(rst_n, 2) |-> fall_through_mode == (s == 3'h1 || s == 3'h5))
		else $error("fall-through decode");
	AST_SYNC_DECODE: assert property ($past(rst_n, 2) |-> sync_partial == (s >= 3'h4 && s <= 3'h6))
		else $error("sync decode");
	AST_ALONE_DECODE: assert property ($past(rst_n, 2) |-> stand_alone == (s != 3'h3 && s != 3'h7))
		else $error("stand-alone decode");
	AST_EF_RISE: assert property ($past(rst_n, 2) && !empty_flag_n && !write_en_n
		&& $past(write_en_n) && $past(write_en_n, 2) |-> s_release(empty_flag_n))
		else $error("empty flag latency");
	AST_FF_RISE: assert property ($past(rst_n, 2) && !full_flag_n && !read_en_n
		&& $past(read_en_n) && $past(read_en_n, 2) |-> s_release(full_flag_n))
		else $error("full flag latency");
	AST_OV_LATENCY: assert property ($past(rst_n, 2) && output_valid_n && !input_room_n
		&& !write_en_n && $past(write_en_n) && $past(write_en_n, 2)
		|-> ##1 output_valid_n [*2] ##1 !output_valid_n) else $error("valid latency");
	AST_IR_LATENCY: assert property ($past(rst_n, 2) && input_room_n && !output_valid_n
		&& !read_en_n && $past(read_en_n) |-> ##1 input_room_n ##1 !input_room_n)
		else $error("room latency");
	AST_RCO_PULSE: assert property (read_chain_out && !fall_through_mode
		|-> !$past(read_en_n) ##1 !read_chain_out) else $error("chain pulse");
endmodule
bind fifo_flag_core fifo_flag_core_monitor mon (.sys_clk, .rst_n, .first_load_strap,
	.read_chain_in, .write_chain_in, .write_en_n, .read_en_n, .empty_flag_n, .full_flag_n,
	.output_valid_n, .input_room_n, .read_chain_out, .fall_through_mode, .sync_partial,
	.stand_alone);
`default_nettype wire

// >>> testbench/fifo_flag_core_tb.sv
// Self-checking bench for the flag core
`timescale 1ns/10ps
`default_nettype none
module fifo_flag_core_tb;
	import fifo_cfg_pkg::*;
	logic sys_clk = 1'b0, rst_n = 1'b0, wr_req = 1'b0, rd_req = 1'b0;
	logic [2:0] strap_sel = 3'h0;
	logic [3:0] empty_offset = 4'h2, full_offset = 4'h2;
	logic first_load_strap, read_chain_in, write_chain_in, write_en_n, read_en_n;
	logic [17:0] write_data, read_data;
	logic empty_flag_n, full_flag_n, output_valid_n, input_room_n, almost_empty_n;
	logic almost_full_n, half_full_n, read_chain_out, fall_through_mode, sync_partial, stand_alone;
	int error_cnt = 0, samples_checked = 0;
	// 40 ns clock
	always #20 sys_clk = ~sys_clk;
	fifo_peer_model peer (.sys_clk, .rst_n, .strap_sel, .wr_req, .rd_req, .first_load_strap,
		.read_chain_in, .write_chain_in, .write_en_n, .write_data, .read_en_n);
	// Depth of 8 keeps fill and drain short
	fifo_flag_core #(.DEPTH(8), .WIDTH(18)) uut (.sys_clk, .rst_n, .first_load_strap,
		.read_chain_in, .write_chain_in, .write_en_n, .write_data, .read_en_n, .empty_offset,
		.full_offset, .read_data, .empty_flag_n, .full_flag_n, .output_valid_n, .input_room_n,
		.almost_empty_n, .almost_full_n, .half_full_n, .read_chain_out, .fall_through_mode,
		.sync_partial, .stand_alone);
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			error_cnt++;
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic do_reset(input logic [2:0] code);
		rst_n <= 1'b0;
		strap_sel <= code;
		repeat (12) @(negedge sys_clk);
		chk(empty_flag_n, 1'b0);
		chk(full_flag_n, 1'b1);
		rst_n <= 1'b1;
		repeat (3) @(negedge sys_clk);
	endtask
	task automatic mode_test();
		for (int c = 0; c < 8; c++) begin
			do_reset(3'(c));
			chk(fall_through_mode, c == 1 || c == 5);
			chk(sync_partial, c >= 4 && c <= 6);
			chk(stand_alone, c != 3 && c != 7);
		end
		$display("mode test done");
	endtask
	task automatic std_test(input logic [2:0] code, input logic dbl);
		do_reset(code);
		wr_req <= 1'b1;
		@(negedge sys_clk);
		wr_req <= 1'b0;
		chk(empty_flag_n, 1'b0);
		@(negedge sys_clk);
		chk(empty_flag_n, !dbl);
		@(negedge sys_clk);
		chk(empty_flag_n, 1'b1);
		wr_req <= 1'b1;
		repeat (7) @(negedge sys_clk);
		wr_req <= 1'b0;
		chk(full_flag_n, 1'b0);
		chk(almost_full_n, 1'b0);
		chk(half_full_n, 1'b0);
		rd_req <= 1'b1;
		@(negedge sys_clk);
		rd_req <= 1'b0;
		chk(read_data, 18'h0);
		chk(full_flag_n, 1'b0);
		@(negedge sys_clk);
		chk(full_flag_n, !dbl);
		// Drain with one read too many, which must be ignored
		rd_req <= 1'b1;
		for (int i = 1; i < 9; i++) begin
			@(negedge sys_clk);
			chk(read_data, 18'(i < 8 ? i : 7));
			chk(read_chain_out, i == 7);
			chk(almost_full_n, i > 1);
			chk(half_full_n, i > 2);
			chk(almost_empty_n, i < 5);
		end
		rd_req <= 1'b0;
		chk(empty_flag_n, 1'b0);
		chk(almost_empty_n, 1'b0);
		$display("standard test done");
	endtask
	task automatic ft_test();
		do_reset(3'h5);
		wr_req <= 1'b1;
		@(negedge sys_clk);
		wr_req <= 1'b0;
		chk(output_valid_n, 1'b1);
		@(negedge sys_clk);
		chk(read_data, 18'h0);
		@(negedge sys_clk);
		chk(output_valid_n, 1'b0);
		// Nine words fit, the tenth is refused
		wr_req <= 1'b1;
		for (int i = 2; i < 11; i++) begin
			@(negedge sys_clk);
			chk(almost_empty_n, i > 3);
		end
		wr_req <= 1'b0;
		chk(input_room_n, 1'b1);
		rd_req <= 1'b1;
		@(negedge sys_clk);
		rd_req <= 1'b0;
		chk(input_room_n, 1'b1);
		@(negedge sys_clk);
		chk(input_room_n, 1'b0);
		rd_req <= 1'b1;
		for (int i = 2; i < 10; i++) begin
			@(negedge sys_clk);
			chk(output_valid_n, i > 8);
			if (i < 9) chk(read_data, 18'(i));
		end
		rd_req <= 1'b0;
		$display("fall-through test done");
	endtask
	initial begin
		mode_test();
		std_test(3'h0, 1'b0);
		std_test(3'h2, 1'b1);
		ft_test();
		end_sim();
	end
	// Watchdog: the tests need about 230 cycles
	initial begin
		repeat (5000) @(posedge sys_clk);
		error_cnt++;
		end_sim();
	end
endmodule
`default_nettype wire
